//--- bench/rom_model.sv
// Behavioural strobed ROM answering the host
`timescale 1ns/10ps
`default_nettype none
module rom_model #(
    parameter int ACC_NS = 300
) (
    input wire logic strobe_n,
    input wire logic [12:0] word_index_lines,
    output logic [7:0] read_byte_lines
);
    logic [12:0] cap = 13'h0000;
    logic ok = 1'b0;
    // Released lines toggle so a stale byte cannot pass
    logic [7:0] junk = 8'h5A;
    always #25 junk = ~junk;
    // Two factory entries stand in for the full tables; elsewhere a
    // stand-in pattern XORs index bits 7..0 with index bits 12..5
    function automatic logic [7:0] content(input logic [12:0] a);
        if ((a >= 13'h0E10 && a < 13'h1000) || a >= 13'h1FA0)
            return 8'h00;
        case (a)
            13'h0005: return 8'h43;
            13'h0006: return 8'h21;
            13'h0007: return 8'h37;
            13'h1000: return 8'h10;
            13'h1001, 13'h1002, 13'h1003: return 8'h00;
            default: return a < 13'h0005 ? 8'h00 : a[7:0] ^ a[12:5];
        endcase
    endfunction
    always @(negedge strobe_n) begin
        cap = word_index_lines;
        #(ACC_NS) ok = !strobe_n;
    end
    always @(posedge strobe_n) ok = 1'b0;
    assign read_byte_lines = !ok ? junk
        : content(cap);
endmodule
`default_nettype wire

//--- bench/rom_read_host_asserts.sv
// Port assertions for the ROM read host
`timescale 1ns/10ps
`default_nettype none
module rom_read_host_asserts (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic reqValid,
    input wire logic reqReady,
    input wire logic rspValid,
    input wire logic strobe_n,
    input wire logic [rom_host_pkg::INDEX_W-1:0] word_index_lines
);
    import rom_host_pkg::*;
    logic [5:0] gapCnt_ff;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Saturates so a long idle never wraps into a false short gap
    always_ff @(posedge ref_clk)
        gapCnt_ff <= !rst_n ? 6'h3F : $fell(strobe_n) ? 6'h01
            : gapCnt_ff + {5'h00, gapCnt_ff != 6'h3F};
    low_width_a:
        assert property ($fell(strobe_n) |-> !strobe_n[*8] ##1 !strobe_n[*4])
            else $error("strobe low too short");
    prech_width_a:
        assert property ($rose(strobe_n) |-> strobe_n[*6]) else $error("prech");
    fall_gap_a:
        assert property ($fell(strobe_n) |-> gapCnt_ff >= 6'h12)
            else $error("gap");
    index_hold_a:
        assert property (!strobe_n && !$fell(strobe_n) |->
            $stable(word_index_lines)) else $error("index moved");
    index_setup_a:
        assert property ($fell(strobe_n) |-> $stable(word_index_lines))
            else $error("index changed with strobe fall");
    busy_refuse_a:
        assert property (!strobe_n |-> !reqReady) else $error("ready busy");
    rsp_pulse_a:
        assert property (rspValid |=> !rspValid) else $error("long pulse");
    rsp_rise_a:
        assert property ($rose(strobe_n) |-> rspValid) else $error("no rsp");
    take_start_a:
        assert property (reqValid && reqReady |-> ##[1:2] $fell(strobe_n))
            else $error("no strobe");
    cover property ($fell(strobe_n));
    cover property (rspValid);
    cover property (reqValid && !reqReady);
endmodule
bind rom_read_host rom_read_host_asserts chk (.ref_clk(ref_clk),
    .rst_n(rst_n), .reqValid(reqValid), .reqReady(reqReady),
    .rspValid(rspValid), .strobe_n(strobe_n),
    .word_index_lines(word_index_lines));
`default_nettype wire

//--- bench/rom_read_host_test.sv
// Self-checking bench for the ROM read host
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, v) begin nTests++; if ((v) !== (e)) begin nMismatch++; \
    $display("MISMATCH %s exp %h got %h", n, e, v); end end
module rom_read_host_test;
    import rom_host_pkg::*;
    logic refClk = 1'b0;
    logic rstN = 1'b0;
    logic reqValid = 1'b0;
    logic [INDEX_W-1:0] reqIndex = 13'h0000;
    logic reqReady;
    logic rspValid;
    logic strobeN;
    logic [DATA_W-1:0] rspByte;
    logic [DATA_W-1:0] romByte;
    logic [INDEX_W-1:0] romIdx;
    int nTests = 0;
    int nMismatch = 0;
    always #12.5 refClk = ~refClk;
    rom_read_host uut (.ref_clk(refClk), .rst_n(rstN), .reqValid(reqValid),
        .reqIndex(reqIndex), .reqReady(reqReady), .rspValid(rspValid),
        .rspByte(rspByte), .strobe_n(strobeN), .word_index_lines(romIdx),
        .read_byte_lines(romByte));
    rom_model rom (.strobe_n(strobeN), .word_index_lines(romIdx),
        .read_byte_lines(romByte));
    task automatic testDone;
        $display("checks %0d mismatches %0d", nTests, nMismatch);
        if (nMismatch == 0 && nTests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic waitHigh(input bit rsp);
        int k;
        k = 0;
        while ((rsp ? rspValid : reqReady) !== 1'b1) begin
            @(negedge refClk);
            k++;
            if (k > 60) begin
                nMismatch++;
                testDone();
            end
        end
    endtask
    // Factory layout where the rules fix it, a stand-in pattern elsewhere
    function automatic logic [7:0] romExp(input logic [12:0] i);
        if ((i >= 13'h0E10 && i < 13'h1000) || i >= 13'h1FA0)
            return 8'h00;
        case (i)
            13'h0005: return 8'h43;
            13'h0006: return 8'h21;
            13'h0007: return 8'h37;
            13'h1000: return 8'h10;
            13'h1001, 13'h1002, 13'h1003: return 8'h00;
            default: return i < 13'h0005 ? 8'h00 : i[7:0] ^ i[12:5];
        endcase
    endfunction
    task automatic readByte(input logic [12:0] i);
        logic [7:0] e;
        e = romExp(i);
        reqValid = 1'b1;
        reqIndex = i;
        waitHigh(1'b0);
        @(negedge refClk);
        reqValid = 1'b0;
        reqIndex = ~i;
        waitHigh(1'b1);
        `CHK("rspByte", e, rspByte)
        `CHK("word_index_lines", i, romIdx)
        `CHK("strobe_n", 1'b1, strobeN)
        `CHK("reqReady", 1'b0, reqReady)
    endtask
    task automatic checkReset;
        `CHK("strobe_n", 1'b1, strobeN)
        `CHK("reqReady", 1'b1, reqReady)
        `CHK("rspValid", 1'b0, rspValid)
        `CHK("rspByte", 8'h00, rspByte)
    endtask
    // Log of 1.01 and antilog of zero, each read as a four-byte entry
    task automatic bcdEntries;
        for (int j = 0; j < 4; j++)
            readByte(13'h0004 + 13'(j));
        for (int j = 0; j < 4; j++)
            readByte(13'h1000 + 13'(j));
    endtask
    // Region edges of the table, issued back to back
    task automatic sweepEdges;
        logic [12:0] pts [8] = '{13'h0000, 13'h0E0F, 13'h0E10, 13'h0FFF,
            13'h1000, 13'h1F9F, 13'h1FA0, 13'h1FFF};
        foreach (pts[j])
            readByte(pts[j]);
    endtask
    task automatic idleRead;
        repeat (40) @(negedge refClk);
        readByte(13'h1ABC);
    endtask
    initial begin
        repeat (6) @(negedge refClk);
        rstN = 1'b1;
        checkReset();
        sweepEdges();
        idleRead();
        bcdEntries();
        testDone();
    end
endmodule
`default_nettype wire

//--- hw/interval_timer.sv
// Up counter of cycles since the last load
`timescale 1ns/10ps
`default_nettype none
module interval_timer (
    input wire logic ref_clk,
    input wire logic rst_n,
    rom_timer_if.timer tmr
);
    import rom_host_pkg::*;
    logic [CNT_W-1:0] count_ff;
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            count_ff <= CNT_RESET;
        end else if (tmr.load) begin
            count_ff <= tmr.loadValue;
        end else if (count_ff != {CNT_W{1'b1}}) begin
            count_ff <= count_ff + 6'h01;
        end
    end
    assign tmr.elapsed = count_ff;
endmodule
`default_nettype wire

//--- hw/rom_read_host.sv
// Host sequencer that reads bytes from an edge-latched strobed ROM
`timescale 1ns/10ps
`default_nettype none
module rom_read_host (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic reqValid,
    input wire logic [rom_host_pkg::INDEX_W-1:0] reqIndex,
    output logic reqReady,
    output logic rspValid,
    output logic [rom_host_pkg::DATA_W-1:0] rspByte,
    output logic strobe_n,
    output logic [rom_host_pkg::INDEX_W-1:0] word_index_lines,
    input wire logic [rom_host_pkg::DATA_W-1:0] read_byte_lines
);
    import rom_host_pkg::*;

    rom_timer_if tmr ();
    interval_timer timer_u (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .tmr(tmr)
    );

    host_state_t state_ff;
    logic strobe_n_ff;
    logic reqReady_ff;
    logic rspValid_ff;
    logic [DATA_W-1:0] rspByte_ff;
    logic [INDEX_W-1:0] index_ff;
    logic [CNT_W-1:0] sinceFall_ff;
    logic [DATA_W-1:0] sync1_ff, sync2_ff, sync3_ff;
    logic armed_ff;

    logic startOk;
    logic startFall;
    logic spacingMet;
    logic lowWidthMet;
    logic accessMet;
    logic holdMet;
    logic dataSettled;
    logic lowDone;
    logic prechMet;
    logic releaseMet;
    logic prechDone;

    // Saturating count since last falling edge, for cycle spacing
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sinceFall_ff <= 6'(CYCLE_CYC);
        end else if (startFall) begin
            sinceFall_ff <= CNT_RESET;
        end else if (sinceFall_ff != {CNT_W{1'b1}}) begin
            sinceFall_ff <= sinceFall_ff + 6'h01;
        end
    end

    // Request taken one edge before the fall, so the index leads the strobe
    // by a full cycle instead of racing it on the same edge
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            armed_ff <= 1'b0;
        end else if (startOk) begin
            armed_ff <= 1'b1; // see [RL8]
        end else if (startFall) begin
            armed_ff <= 1'b0;
        end
    end

    // Data pins are asynchronous to ref_clk; three stages
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sync1_ff <= DATA_RESET;
            sync2_ff <= DATA_RESET;
            sync3_ff <= DATA_RESET;
        end else begin
            sync1_ff <= read_byte_lines;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    // Low width and access both end the low phase; access bound includes sync
    assign lowWidthMet = tmr.elapsed >= 6'(LOW_CYC); // see [RL6]
    assign accessMet = tmr.elapsed >= 6'(ACCESS_CYC);
    // Index stays put the whole low phase, so the hold is met on the way
    assign holdMet = tmr.elapsed >= 6'(HOLD_CYC); // see [RL9]
    // Second and third stages agree: the byte has stopped moving
    assign dataSettled = sync2_ff == sync3_ff;
    assign lowDone = lowWidthMet && accessMet && holdMet && dataSettled;
    assign prechMet = tmr.elapsed >= 6'(PRECH_CYC); // see [RL7]
    // Next fall also waits until the read lines are off the bus
    assign releaseMet = tmr.elapsed >= 6'(RELEASE_CYC);
    assign prechDone = prechMet && releaseMet;
    assign spacingMet = sinceFall_ff >= 6'(CYCLE_CYC); // see [RL5]
    assign startOk = state_ff == ST_IDLE && !armed_ff && reqValid
        && reqReady_ff && spacingMet;
    assign startFall = state_ff == ST_IDLE && armed_ff;

    always_comb begin
        tmr.load = 1'b0;
        tmr.loadValue = CNT_RESET;
        if (startFall) begin
            tmr.load = 1'b1;
        end else if (state_ff == ST_LOW && lowDone) begin
            tmr.load = 1'b1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            state_ff <= ST_IDLE;
        end else begin
            unique case (state_ff)
                ST_IDLE: begin
                    if (startFall) begin
                        state_ff <= ST_LOW;
                    end
                end
                ST_LOW: begin
                    if (lowDone) begin
                        state_ff <= ST_PRECH;
                    end
                end
                ST_PRECH: begin
                    if (prechDone) begin
                        state_ff <= ST_IDLE;
                    end
                end
                default: state_ff <= ST_IDLE;
            endcase
        end
    end

    // Index set one cycle before the fall: zero setup met with margin
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            index_ff <= INDEX_RESET;
        end else if (startOk) begin
            index_ff <= reqIndex; // see [RL8] [RL10]
        end
    end

    // Index stays put through the whole low phase, beyond the hold time
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            strobe_n_ff <= 1'b1;
        end else if (startFall) begin
            strobe_n_ff <= 1'b0; // see [RL2] [RL9]
        end else if (state_ff == ST_LOW && lowDone) begin
            strobe_n_ff <= 1'b1; // see [RL3]
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            reqReady_ff <= 1'b1;
        end else if (startOk) begin
            reqReady_ff <= 1'b0;
        end else if (state_ff == ST_PRECH && prechDone) begin
            reqReady_ff <= 1'b1;
        end
    end

    // Pulse on the edge that raises the strobe
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rspValid_ff <= 1'b0;
        end else begin
            rspValid_ff <= state_ff == ST_LOW && lowDone; // see [RL4]
        end
    end

    // Byte taken while strobe still low: device holds it there
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rspByte_ff <= DATA_RESET;
        end else if (state_ff == ST_LOW && lowDone) begin
            rspByte_ff <= sync3_ff; // see [RL1] [RL16]
        end
    end

    assign reqReady = reqReady_ff;
    assign rspValid = rspValid_ff;
    assign rspByte = rspByte_ff;
    assign strobe_n = strobe_n_ff;
    assign word_index_lines = index_ff;
endmodule
`default_nettype wire

//--- pkg/rom_host_pkg.sv
// Constants and types for the edge-latched ROM read host
// Operation
// [RL1] Memory holds 8192 bytes, 13-bit index, one byte per read cycle.
// [RL2] Device captures index on strobe falling edge; no external latch needed.
// [RL3] Strobe high floats read lines and puts memory in standby.
// [RL4] Data valid within 200/250/300 ns of strobe fall per grade.
// [RL5] Host spaces strobe falling edges at least 300/375/450 ns apart.
// [RL6] Host holds strobe low at least 200/250/300 ns.
// [RL7] Host keeps strobe high at least 100/125/150 ns precharge.
// [RL8] Host presents stable index no later than strobe fall.
// [RL9] Host holds index at least 60/60/75 ns after strobe fall.
// [RL10] After hold time index may change; device ignores it until next fall.
// [RL11] Read lines float within 60/60/75 ns after strobe rises.
// [RL12] Log pattern: words 0..3599 hold log10 of 1.00..9.99.
// [RL13] Antilog pattern: words 4096..8095 hold antilog of 0.000..0.999.
// [RL14] Words 3600..4095 and 8096..8191 are zero.
// [RL15] Entry is eight BCD digits over four bytes, most significant first.
// [RL16] Device keeps driving captured byte while strobe stays low.
package rom_host_pkg;
    localparam int CLK_PERIOD_NS = 25;
    localparam int INDEX_W = 13;
    localparam int DATA_W = 8;
    localparam int ROM_WORDS = 8192;
    // Slowest grade figures, safe for every part
    localparam int STROBE_LOW_WIDTH_NS = 300;
    localparam int STROBE_ACCESS_INTERVAL_NS = 300;
    localparam int PRECHARGE_INTERVAL_NS = 150;
    localparam int STROBE_CYCLE_INTERVAL_NS = 450;
    localparam int INDEX_HOLD_INTERVAL_NS = 75;
    localparam int OUTPUT_RELEASE_INTERVAL_NS = 75;
    localparam int SYNC_LAT_CYC = 3;
    // Least times round up
    localparam int LOW_CYC =
        (STROBE_LOW_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACCESS_CYC =
        (STROBE_ACCESS_INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS
        + SYNC_LAT_CYC;
    localparam int PRECH_CYC =
        (PRECHARGE_INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CYCLE_CYC =
        (STROBE_CYCLE_INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_CYC =
        (INDEX_HOLD_INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RELEASE_CYC =
        (OUTPUT_RELEASE_INTERVAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 6;
    localparam logic [CNT_W-1:0] CNT_RESET = 6'h00;
    localparam logic [INDEX_W-1:0] INDEX_RESET = 13'h0000;
    localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
    typedef enum logic [2:0] {
        ST_IDLE, ST_LOW, ST_PRECH
    } host_state_t;
endpackage

//--- pkg/rom_timer_if.sv
// Carrier between the host sequencer and its interval timer
`timescale 1ns/10ps
`default_nettype none
interface rom_timer_if;
    import rom_host_pkg::*;
    logic load;
    logic [CNT_W-1:0] loadValue;
    logic [CNT_W-1:0] elapsed;
    modport owner (output load, output loadValue, input elapsed);
    modport timer (input load, input loadValue, output elapsed);
endinterface
`default_nettype wire
